// File: core/rdio_pkg.sv
// Package for the relay and digital I/O port block.
// Assumes a single clock domain and the simple strobe register port.
package rdio_pkg;
	// Register offsets (byte addresses, one word each)
	localparam logic [7:0] RELAY_OFF = 8'h00;
	localparam logic [7:0] PORTA_OFF = 8'h04;
	localparam logic [7:0] PORTB_OFF = 8'h08;
	localparam logic [7:0] PORTC_OFF = 8'h0c;
	localparam logic [7:0] PORTD_OFF = 8'h10;
	localparam logic [7:0] DIR_OFF = 8'h14;
	localparam logic [7:0] BITSET_OFF = 8'h18;
	localparam logic [7:0] IRQ_EN_OFF = 8'h1c;
	localparam logic [7:0] IRQ_STAT_OFF = 8'h20;
	localparam logic [7:0] IRQ_MASK_OFF = 8'h24;
	localparam logic [7:0] IRQ_CUR_OFF = 8'h28;
	// Single bit write command fields
	localparam int BIT_SEL_LSB = 0;
	localparam int BIT_TGT_LSB = 4;
	localparam int BIT_VAL_POS = 8;
	// Targets of a single bit write
	localparam logic [1:0] TGT_RELAY = 2'h0;
	localparam logic [1:0] TGT_PORTC = 2'h1;
	localparam logic [1:0] TGT_PORTD = 2'h2;
	// Direction register fields
	localparam int DIR_C_POS = 0;
	localparam int DIR_D_POS = 1;
	// Reset values
	localparam logic [15:0] RELAY_RST = 16'h0000;
	localparam logic [1:0] DIR_RST = 2'h0;
	localparam logic [7:0] UNMAPPED_RD = 8'h00;
endpackage : rdio_pkg

// File: core/rdio_edge.sv
// Synchroniser and rising edge detector for one asynchronous input bit.
// Assumes clk is the bus clock; ce freezes all state.
`timescale 1ns/1ps
`default_nettype none
module rdio_edge
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic async_in,
	output logic level,
	output logic rise
);
	logic meta_q;
	logic sync_q;
	logic prev_q;

	// Two stages before anything looks at the level
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
			prev_q <= 1'b0;
		end
		else if (ce)
		begin
			meta_q <= async_in;
			sync_q <= meta_q;
			prev_q <= sync_q;
		end
	end

	assign level = sync_q;
	assign rise = ce & sync_q & ~prev_q;
endmodule : rdio_edge
`default_nettype wire

// File: core/rdio_top.sv
// Relay outputs, two input ports, two bidirectional ports, two edge interrupts.
// Assumes a synchronous host register port and asynchronous field pins.
//
// Strobed register access and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module rdio_top
#(
	parameter int RELAYS = 16
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	output logic [RELAYS-1:0] relay_drive,
	input wire logic [7:0] port_a_in,
	input wire logic [7:0] port_b_in,
	input wire logic [7:0] port_c_in,
	output logic [7:0] port_c_out,
	output logic [7:0] port_c_oe,
	input wire logic [7:0] port_d_in,
	output logic [7:0] port_d_out,
	output logic [7:0] port_d_oe,
	input wire logic [1:0] irq_line,
	output logic irq
);
	////////////////////////////////////////////////////////////////////////
	// Synchronisers
	logic [33:0] raw_in;
	logic [33:0] sync_lvl;
	logic [33:0] sync_rise;
	assign raw_in = {irq_line, port_d_in, port_c_in, port_b_in, port_a_in};

	genvar gi;
	generate
		for (gi = 0; gi < 34; gi = gi + 1)
		begin : g_sync
			rdio_edge u_edge
			(
				.clk(clk),
				.reset(reset),
				.ce(ce),
				.async_in(raw_in[gi]),
				.level(sync_lvl[gi]),
				.rise(sync_rise[gi])
			);
		end
	endgenerate

	wire [7:0] a_lvl = sync_lvl[7:0];
	wire [7:0] b_lvl = sync_lvl[15:8];
	wire [7:0] c_lvl = sync_lvl[23:16];
	wire [7:0] d_lvl = sync_lvl[31:24];
	wire [1:0] irq_rise = sync_rise[33:32];

	////////////////////////////////////////////////////////////////////////
	// Registers
	logic [RELAYS-1:0] relay_q;
	logic [RELAYS-1:0] relay_d;
	logic [7:0] c_out_q;
	logic [7:0] c_out_d;
	logic [7:0] d_out_q;
	logic [7:0] d_out_d;
	logic [1:0] dir_q;
	logic [1:0] irq_en_q;
	logic [1:0] irq_stat_q;
	logic [1:0] irq_stat_d;
	logic [1:0] irq_mask_q;
	logic [1:0] cur_q;
	logic [1:0] cur_d;
	logic [31:0] rdata_q;
	logic irq_q;

	// Decode reused for the write selects; the read mux uses its own case on addr
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction : hit

	wire wr_en = wr & ce;
	wire wr_relay = wr_en & hit(addr, rdio_pkg::RELAY_OFF);
	wire wr_c = wr_en & hit(addr, rdio_pkg::PORTC_OFF);
	wire wr_d = wr_en & hit(addr, rdio_pkg::PORTD_OFF);
	wire wr_dir = wr_en & hit(addr, rdio_pkg::DIR_OFF);
	wire wr_bit = wr_en & hit(addr, rdio_pkg::BITSET_OFF);
	wire wr_ien = wr_en & hit(addr, rdio_pkg::IRQ_EN_OFF);
	wire wr_stat = wr_en & hit(addr, rdio_pkg::IRQ_STAT_OFF);
	wire wr_mask = wr_en & hit(addr, rdio_pkg::IRQ_MASK_OFF);

	wire [3:0] bit_sel = wdata[rdio_pkg::BIT_SEL_LSB +: 4];
	wire [1:0] bit_tgt = wdata[rdio_pkg::BIT_TGT_LSB +: 2];
	wire bit_val = wdata[rdio_pkg::BIT_VAL_POS];

	// Single bit writes modify one bit, whole writes replace all
	always_comb
	begin
		relay_d = relay_q;
		c_out_d = c_out_q;
		d_out_d = d_out_q;
		if (wr_relay)
			relay_d = wdata[RELAYS-1:0];
		else if (wr_bit && bit_tgt == rdio_pkg::TGT_RELAY && bit_sel < RELAYS)
			relay_d[bit_sel] = bit_val;
		if (wr_c)
			c_out_d = wdata[7:0];
		else if (wr_bit && bit_tgt == rdio_pkg::TGT_PORTC && bit_sel < 4'h8)
			c_out_d[bit_sel[2:0]] = bit_val;
		if (wr_d)
			d_out_d = wdata[7:0];
		else if (wr_bit && bit_tgt == rdio_pkg::TGT_PORTD && bit_sel < 4'h8)
			d_out_d[bit_sel[2:0]] = bit_val;
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupts
	wire [1:0] irq_evt = irq_rise & irq_en_q;
	wire [1:0] pend = irq_stat_q & irq_mask_q;

	// Set wins over a clear in the same cycle
	always_comb
	begin
		irq_stat_d = irq_stat_q;
		if (wr_stat)
			irq_stat_d = irq_stat_q & ~wdata[1:0];
		irq_stat_d = irq_stat_d | irq_evt;
	end

	// One channel presented at a time; it stays current until its status is cleared or masked
	always_comb
	begin
		cur_d = cur_q;
		if ((cur_q & pend) == 2'h0)
		begin
			if (pend[0])
				cur_d = 2'h1;
			else if (pend[1])
				cur_d = 2'h2;
			else
				cur_d = 2'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read mux: ports in output mode read their driven value
	wire [7:0] c_rd = dir_q[rdio_pkg::DIR_C_POS] ? c_out_q : c_lvl;
	wire [7:0] d_rd = dir_q[rdio_pkg::DIR_D_POS] ? d_out_q : d_lvl;
	logic [31:0] rd_mux;
	always_comb
	begin
		rd_mux = {24'h000000, rdio_pkg::UNMAPPED_RD};
		case (addr)
			rdio_pkg::RELAY_OFF: rd_mux = 32'(relay_q);
			rdio_pkg::PORTA_OFF: rd_mux = {24'h000000, a_lvl};
			rdio_pkg::PORTB_OFF: rd_mux = {24'h000000, b_lvl};
			rdio_pkg::PORTC_OFF: rd_mux = {24'h000000, c_rd};
			rdio_pkg::PORTD_OFF: rd_mux = {24'h000000, d_rd};
			rdio_pkg::DIR_OFF: rd_mux = {30'h00000000, dir_q};
			rdio_pkg::IRQ_EN_OFF: rd_mux = {30'h00000000, irq_en_q};
			rdio_pkg::IRQ_STAT_OFF: rd_mux = {30'h00000000, irq_stat_q};
			rdio_pkg::IRQ_MASK_OFF: rd_mux = {30'h00000000, irq_mask_q};
			rdio_pkg::IRQ_CUR_OFF: rd_mux = {30'h00000000, cur_q};
			default: rd_mux = {24'h000000, rdio_pkg::UNMAPPED_RD};
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// State
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			relay_q <= RELAYS'(rdio_pkg::RELAY_RST);
			c_out_q <= 8'h00;
			d_out_q <= 8'h00;
			dir_q <= rdio_pkg::DIR_RST;
			irq_en_q <= 2'h0;
			irq_stat_q <= 2'h0;
			irq_mask_q <= 2'h0;
			cur_q <= 2'h0;
			rdata_q <= 32'h00000000;
			irq_q <= 1'b0;
		end
		else if (ce)
		begin
			relay_q <= relay_d;
			c_out_q <= c_out_d;
			d_out_q <= d_out_d;
			if (wr_dir)
				dir_q <= wdata[1:0];
			if (wr_ien)
				irq_en_q <= wdata[1:0];
			if (wr_mask)
				irq_mask_q <= wdata[1:0];
			irq_stat_q <= irq_stat_d;
			cur_q <= cur_d;
			rdata_q <= rd ? rd_mux : 32'h00000000;
			irq_q <= |(irq_stat_d & irq_mask_q);
		end
	end

	assign rdata = rdata_q;
	assign irq = irq_q;
	assign relay_drive = relay_q;
	assign port_c_out = c_out_q;
	assign port_d_out = d_out_q;
	// Whole port turns around; no per-bit direction exists
	assign port_c_oe = {8{dir_q[rdio_pkg::DIR_C_POS]}};
	assign port_d_oe = {8{dir_q[rdio_pkg::DIR_D_POS]}};

	////////////////////////////////////////////////////////////////////////
	// Checks
	// Reset and bus
	a_relay_reset: assert property (@(posedge clk)
		reset |=> relay_drive == '0)
		else $error("relays not released after reset");

	a_dir_reset: assert property (@(posedge clk)
		reset |=> port_c_oe == 8'h00 && port_d_oe == 8'h00)
		else $error("ports not input after reset");

	a_irq_reset: assert property (@(posedge clk)
		reset |=> !irq)
		else $error("interrupt high after reset");

	a_rdata_reset: assert property (@(posedge clk)
		reset |=> rdata == 32'h00000000)
		else $error("read data not clear after reset");

	a_rdata_idle: assert property (@(posedge clk) disable iff (reset)
		ce && !rd |=> rdata == 32'h00000000)
		else $error("read data stood too long");

	a_relay_whole: assert property (@(posedge clk) disable iff (reset)
		wr_relay |=> relay_drive == $past(wdata[RELAYS-1:0]))
		else $error("relay whole write lost");

	a_relay_bit: assert property (@(posedge clk) disable iff (reset)
		wr_bit && bit_tgt == rdio_pkg::TGT_RELAY && bit_sel < RELAYS
		|=> relay_drive[$past(bit_sel)] == $past(bit_val))
		else $error("relay bit write lost");

	a_relay_hold: assert property (@(posedge clk) disable iff (reset)
		ce && !wr_relay && !wr_bit |=> $stable(relay_drive))
		else $error("relay changed without a write");

	a_relay_read: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::RELAY_OFF |=> rdata[RELAYS-1:0] == $past(relay_q))
		else $error("relay readback wrong");

	a_bitset_read: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::BITSET_OFF |=> rdata == 32'h00000000)
		else $error("bit command reads nonzero");

	// Ports
	a_a_read: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::PORTA_OFF |=> rdata == {24'h000000, $past(a_lvl)})
		else $error("port a read wrong");

	a_b_read: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::PORTB_OFF |=> rdata == {24'h000000, $past(b_lvl)})
		else $error("port b read wrong");

	a_c_readback: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::PORTC_OFF && dir_q[0] |=> rdata[7:0] == $past(c_out_q))
		else $error("port c readback wrong");

	a_d_readback: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::PORTD_OFF && dir_q[1] |=> rdata[7:0] == $past(d_out_q))
		else $error("port d readback wrong");

	a_c_whole: assert property (@(posedge clk) disable iff (reset)
		wr_c |=> port_c_out == $past(wdata[7:0]))
		else $error("port c whole write lost");

	a_d_whole: assert property (@(posedge clk) disable iff (reset)
		wr_d |=> port_d_out == $past(wdata[7:0]))
		else $error("port d whole write lost");

	a_c_bit: assert property (@(posedge clk) disable iff (reset)
		wr_bit && bit_tgt == rdio_pkg::TGT_PORTC && bit_sel < 4'h8
		|=> port_c_out[$past(bit_sel[2:0])] == $past(bit_val))
		else $error("port c bit write lost");

	a_d_bit: assert property (@(posedge clk) disable iff (reset)
		wr_bit && bit_tgt == rdio_pkg::TGT_PORTD && bit_sel < 4'h8
		|=> port_d_out[$past(bit_sel[2:0])] == $past(bit_val))
		else $error("port d bit write lost");

	a_dir_oe: assert property (@(posedge clk) disable iff (reset)
		wr_dir |=> port_d_oe == {8{$past(wdata[1])}})
		else $error("direction write lost");

	a_c_dir_oe: assert property (@(posedge clk) disable iff (reset)
		wr_dir |=> port_c_oe == {8{$past(wdata[0])}})
		else $error("port c direction write lost");

	a_dir_read: assert property (@(posedge clk) disable iff (reset)
		rd && ce && addr == rdio_pkg::DIR_OFF |=> rdata[31:2] == 30'h00000000)
		else $error("direction has extra bits");

	// Interrupts
	a_irq_enabled: assert property (@(posedge clk) disable iff (reset)
		irq_rise[0] && irq_en_q[0] |=> irq_stat_q[0])
		else $error("edge did not set status");

	a_irq_enabled1: assert property (@(posedge clk) disable iff (reset)
		irq_rise[1] && irq_en_q[1] |=> irq_stat_q[1])
		else $error("edge did not set status one");

	a_irq_disabled: assert property (@(posedge clk) disable iff (reset)
		ce && !irq_en_q[1] && !irq_stat_q[1] && !wr_stat |=> !irq_stat_q[1])
		else $error("disabled channel set status");

	a_irq_disabled0: assert property (@(posedge clk) disable iff (reset)
		ce && !irq_en_q[0] && !irq_stat_q[0] && !wr_stat |=> !irq_stat_q[0])
		else $error("disabled channel zero set status");

	a_irq_level: assert property (@(posedge clk) disable iff (reset)
		ce |=> irq == |(irq_stat_q & $past(irq_mask_q)))
		else $error("interrupt level wrong");

	a_cur_onehot: assert property (@(posedge clk) disable iff (reset)
		cur_q != 2'h3)
		else $error("both channels presented");

	a_cur_hold: assert property (@(posedge clk) disable iff (reset)
		ce && (cur_q & pend) != 2'h0 |=> cur_q == $past(cur_q))
		else $error("current channel left early");

	a_cur_first: assert property (@(posedge clk) disable iff (reset)
		ce && cur_q == 2'h0 && pend == 2'h3 |=> cur_q == 2'h1)
		else $error("lower channel not first");
endmodule : rdio_top
`default_nettype wire

// File: tb/rdio_field.sv
// Field wiring model: external drivers on the two bidirectional ports.
// Assumes the bench sets the external levels; the pins resolve here.
`timescale 1ns/1ps
`default_nettype none
module rdio_field
(
	input wire logic [7:0] c_out,
	input wire logic [7:0] c_oe,
	input wire logic [7:0] d_out,
	input wire logic [7:0] d_oe,
	input wire logic [7:0] c_ext,
	input wire logic [7:0] d_ext,
	output logic [7:0] c_pin,
	output logic [7:0] d_pin
);
	// Device wins where it drives, field level elsewhere
	assign c_pin = (c_oe & c_out) | (~c_oe & c_ext);
	assign d_pin = (d_oe & d_out) | (~d_oe & d_ext);
endmodule : rdio_field
`default_nettype wire

// File: tb/rdio_top_tb.sv
// Bench for the relay and digital I/O block: register tasks and checks.
// Assumes the 40 ns bus clock and the field model rdio_field.
`timescale 1ns/1ps
`default_nettype none
module rdio_top_tb;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] pa = 8'h00;
	logic [7:0] pb = 8'h00;
	logic [7:0] c_ext = 8'h96;
	logic [7:0] d_ext = 8'h69;
	logic [1:0] irq_line = 2'h0;
	logic [31:0] rdata;
	logic [15:0] relay;
	logic [7:0] c_in, c_out, c_oe, d_in, d_out, d_oe;
	logic irq;
	int n_fail = 0;
	int comparisons = 0;
	always #20 clk = ~clk;
	rdio_top #(.RELAYS(16)) u_rdio_top
	(
		.clk(clk), .reset(reset), .ce(1'b1), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .relay_drive(relay),
		.port_a_in(pa), .port_b_in(pb), .port_c_in(c_in), .port_c_out(c_out),
		.port_c_oe(c_oe), .port_d_in(d_in), .port_d_out(d_out), .port_d_oe(d_oe),
		.irq_line(irq_line), .irq(irq)
	);
	rdio_field u_rdio_field
	(
		.c_out(c_out), .c_oe(c_oe), .d_out(d_out), .d_oe(d_oe),
		.c_ext(c_ext), .d_ext(d_ext), .c_pin(c_in), .d_pin(d_in)
	);
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wreg
	// Read data stand only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, input logic [31:0] e, input string n);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(n, e, rdata);
	endtask : rreg
	task automatic finish_test;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : finish_test
	initial
	begin
		repeat (20000) @(posedge clk);
		n_fail++;
		finish_test;
	end
	////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		#1;
		chk("relay", 32'h0, {16'h0, relay});
		chk("c_oe", 32'h0, {24'h0, c_oe});
		chk("d_oe", 32'h0, {24'h0, d_oe});
		rreg(rdio_pkg::RELAY_OFF, 32'h0, "relay reg");
		wreg(rdio_pkg::RELAY_OFF, 32'ha5c3);
		rreg(rdio_pkg::RELAY_OFF, 32'ha5c3, "relay reg");
		chk("relay", 32'ha5c3, {16'h0, relay});
		wreg(rdio_pkg::BITSET_OFF, 32'h102);
		wreg(rdio_pkg::BITSET_OFF, 32'h00f);
		wreg(8'h40, 32'hffffffff);
		rreg(8'h40, 32'h0, "unmapped");
		rreg(rdio_pkg::RELAY_OFF, 32'h25c7, "relay bit");
		chk("relay", 32'h25c7, {16'h0, relay});
		@(posedge clk);
		pa <= 8'h3c;
		pb <= 8'hc3;
		repeat (4) @(posedge clk);
		wreg(rdio_pkg::PORTA_OFF, 32'h0);
		rreg(rdio_pkg::PORTA_OFF, 32'h3c, "port a");
		rreg(rdio_pkg::PORTB_OFF, 32'hc3, "port b");
		rreg(rdio_pkg::PORTC_OFF, 32'h96, "port c in");
		wreg(rdio_pkg::DIR_OFF, 32'h1);
		wreg(rdio_pkg::PORTC_OFF, 32'h5a);
		rreg(rdio_pkg::PORTC_OFF, 32'h5a, "port c out");
		rreg(rdio_pkg::PORTD_OFF, 32'h69, "port d in");
		chk("c_oe", 32'hff, {24'h0, c_oe});
		chk("d_oe", 32'h0, {24'h0, d_oe});
		wreg(rdio_pkg::DIR_OFF, 32'h2);
		wreg(rdio_pkg::BITSET_OFF, 32'h127);
		chk("d_out", 32'h80, {24'h0, d_out});
		rreg(rdio_pkg::PORTD_OFF, 32'h80, "port d out");
		rreg(rdio_pkg::PORTC_OFF, 32'h96, "port c back");
		// Edges on a disabled channel must leave no trace
		wreg(rdio_pkg::IRQ_MASK_OFF, 32'h3);
		@(posedge clk);
		irq_line <= 2'h1;
		repeat (6) @(posedge clk);
		rreg(rdio_pkg::IRQ_STAT_OFF, 32'h0, "off status");
		@(posedge clk);
		irq_line <= 2'h0;
		wreg(rdio_pkg::IRQ_EN_OFF, 32'h3);
		repeat (4) @(posedge clk);
		irq_line <= 2'h3;
		repeat (6) @(posedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		rreg(rdio_pkg::IRQ_STAT_OFF, 32'h3, "status");
		rreg(rdio_pkg::IRQ_CUR_OFF, 32'h1, "current");
		wreg(rdio_pkg::IRQ_STAT_OFF, 32'h1);
		rreg(rdio_pkg::IRQ_CUR_OFF, 32'h2, "current");
		chk("irq", 32'h1, {31'h0, irq});
		wreg(rdio_pkg::IRQ_STAT_OFF, 32'h2);
		rreg(rdio_pkg::IRQ_STAT_OFF, 32'h0, "status");
		chk("irq", 32'h0, {31'h0, irq});
		// Masked channel still latches, but the output stays low
		wreg(rdio_pkg::IRQ_MASK_OFF, 32'h2);
		@(posedge clk);
		irq_line <= 2'h2;
		repeat (4) @(posedge clk);
		irq_line <= 2'h3;
		repeat (6) @(posedge clk);
		chk("irq", 32'h0, {31'h0, irq});
		rreg(rdio_pkg::IRQ_STAT_OFF, 32'h1, "masked");
		finish_test;
	end
endmodule : rdio_top_tb
`default_nettype wire
